// ---- fpc_pkg.sv ----
package fpc_pkg;
  // ****************************************
  // register port map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ACW_OFFSET = 8'h00;
  localparam logic [7:0] GPR_BASE = 8'h80;
  localparam logic [31:0] ACW_WMASK = 32'hff1f_117f;
  // normalizing mode on, all floating exceptions masked
  localparam logic [31:0] ACW_RESET = 32'h3f00_0000;
  // ****************************************
  // arithmetic controls fields
  // ****************************************
  localparam int CC_LSB = 0;
  localparam int AS_LSB = 3;
  localparam int IOV_FLAG = 8;
  localparam int IOV_MASK = 12;
  localparam int FLAG_LSB = 16;
  localparam int MASK_LSB = 24;
  localparam int NORM_BIT = 29;
  localparam int RND_LSB = 30;
  localparam int EXC_OV = 0;
  localparam int EXC_UN = 1;
  localparam int EXC_INV = 2;
  localparam int EXC_ZD = 3;
  localparam int EXC_INX = 4;
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_DOWN = 2'h1;
  localparam logic [1:0] RND_UP = 2'h2;
  localparam logic [1:0] RND_ZERO = 2'h3;
  // ****************************************
  // real formats
  // ****************************************
  localparam int REAL_BIAS = 127;
  localparam int LONG_BIAS = 1023;
  localparam int EXT_BIAS = 16383;
  localparam int REAL_EXP_MAX = 255;
  localparam int LONG_EXP_MAX = 2047;
  localparam int REAL_FRAC_W = 23;
  localparam int LONG_FRAC_W = 52;
  localparam int EXT_FRAC_W = 63;
  localparam int EXT_INT_BIT = 63;
  localparam logic [14:0] EXT_EXP_ONES = 15'h7fff;
  // ****************************************
  // classification codes
  // ****************************************
  localparam logic [2:0] CLS_ZERO = 3'h0;
  localparam logic [2:0] CLS_DENORM = 3'h1;
  localparam logic [2:0] CLS_NORMAL = 3'h2;
  localparam logic [2:0] CLS_INF = 3'h3;
  localparam logic [2:0] CLS_QNAN = 3'h4;
  localparam logic [2:0] CLS_SNAN = 3'h5;
  typedef enum logic [3:0] {
    OP_NONE, OP_MOV1, OP_MOV2, OP_MOV3,
    OP_MOVR_G2F, OP_MOVRL_G2F, OP_MOVRE_G2F,
    OP_MOVR_F2G, OP_MOVRL_F2G, OP_MOVRE_F2G,
    OP_CLASS, OP_CLASSL, OP_ARITH_FP, OP_ARITH_R, OP_ARITH_RL
  } fpc_op_t;
endpackage

// ---- fpc_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1: overflowing narrowed result becomes signed infinity; code gives largest finite when rounding toward zero or against the sign
// RL2: max exponent, nonzero fraction means NaN
// RL3: top fraction bit set quiet, clear signaling
// RL4: signaling NaN operand raises invalid operation
// RL5: biases 127, 1023, 16383 per format
// RL6: implied integer bit for real, long real
// RL7: extended integer bit 63, fraction top 62
// RL8: nonzero exponent, clear integer bit is reserved
// RL9: exponent 8/11/15 bits, fraction 23/52/63
// RL10: four extended floating registers beside general ones
// RL11: one, two, three general words per format
// RL12: software aligns long even, extended by four
// RL13: floating registers always hold extended real
// RL14: real moves convert both ways, long pairs
// RL15: extended move copies 80 bits, three words
// RL16: plain moves copy general words bit exact
// RL17: arithmetic to floating register stores extended
// RL18: condition code 0-2, status 3-6
// RL19: integer overflow flag 8, mask 12
// RL20: floating flags at bits 16 to 20
// RL21: floating masks at bits 24 to 28
// RL22: record flag, fault only when unmasked
// RL23: denormal source without normalizing mode faults
// RL24: bits 30-31 choose rounding mode
// RL25: narrowing rounds, sets overflow underflow inexact
module fpc_unit (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [fpc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic opValid,
  input wire fpc_pkg::fpc_op_t opCode,
  input wire logic [4:0] opSrc,
  input wire logic [4:0] opDst,
  input wire logic [79:0] arithResult,
  input wire logic [4:0] arithExc,
  output logic opDone,
  output logic reservedFault,
  output logic excFault
);
  import fpc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0][31:0] gpr;
    logic [3:0][79:0] fpr;
    logic [31:0] acw;
    logic [31:0] rdData;
    logic done;
    logic faultRes;
    logic faultExc;
  } fpc_state_t;

  fpc_state_t st;
  fpc_state_t next_st;
  logic rstMeta_b;
  logic rstSync_b;

  // ****************************************
  // format helpers
  // ****************************************
  function automatic logic [2:0] classify(input logic eOnes, input logic eZero,
                                          input logic fNz, input logic fTop);
    return eOnes ? (!fNz ? CLS_INF : (fTop ? CLS_QNAN : CLS_SNAN))
                 : (eZero ? (fNz ? CLS_DENORM : CLS_ZERO) : CLS_NORMAL);
  endfunction

  function automatic logic isReserved(input logic [79:0] x);
    return (x[78:64] != 15'h0000) && !x[EXT_INT_BIT];
  endfunction

  function automatic logic [79:0] widen(input logic [63:0] v, input logic isLong,
                                        output logic isDen, output logic isSnan);
    logic sgn;
    logic [14:0] eN;
    logic [62:0] f;
    logic [62:0] fsh;
    int bias;
    int emaxN;
    int lz;
    int ee;
    logic [79:0] r;
    sgn = isLong ? v[63] : v[31];
    // RL9: field widths per format
    eN = isLong ? {4'h0, v[62:52]} : {7'h00, v[30:23]};
    f = isLong ? {v[51:0], 11'h000} : {v[22:0], 40'h00_0000_0000};
    bias = isLong ? LONG_BIAS : REAL_BIAS;
    emaxN = isLong ? LONG_EXP_MAX : REAL_EXP_MAX;
    lz = 0;
    for (int i = 0; i < EXT_FRAC_W; i++)
      if (f[i])
        lz = EXT_FRAC_W - 1 - i;
    fsh = f << (lz + 1);
    isDen = (eN == 15'h0000) && (f != '0);
    // RL3: quiet bit is top fraction bit
    isSnan = (int'(eN) == emaxN) && (f != '0) && !f[EXT_FRAC_W-1];
    r = {sgn, 79'h0};
    if (int'(eN) == emaxN)
      r = {sgn, EXT_EXP_ONES, 1'b1, f | (isSnan ? {1'b1, 62'h0} : 63'h0)};
    else if (isDen)
    begin
      ee = EXT_BIAS - bias - lz;
      r = {sgn, 15'(ee), 1'b1, fsh};
    end
    else if (eN != 15'h0000)
    begin
      // RL5: rebias into extended
      ee = int'(eN) - bias + EXT_BIAS;
      // RL6: implied integer bit made explicit
      r = {sgn, 15'(ee), 1'b1, f};
    end
    return r;
  endfunction

  function automatic logic [63:0] narrow(input logic [79:0] x, input logic isLong,
                                         input logic [1:0] rm, output logic [4:0] fl);
    logic sgn;
    logic [62:0] f;
    logic [63:0] kept;
    logic [63:0] rem;
    logic [63:0] half;
    logic inc;
    logic bigInf;
    int bias;
    int emax;
    int nf;
    int sh;
    int ue;
    sgn = x[79];
    f = x[62:0];
    fl = 5'h00;
    inc = 1'b0;
    bigInf = 1'b0;
    bias = isLong ? LONG_BIAS : REAL_BIAS;
    emax = isLong ? LONG_EXP_MAX : REAL_EXP_MAX;
    nf = isLong ? LONG_FRAC_W : REAL_FRAC_W;
    sh = EXT_FRAC_W - nf;
    kept = {1'b0, f} >> sh;
    rem = {1'b0, f} & ((64'h1 << sh) - 64'h1);
    half = 64'h1 << (sh - 1);
    ue = int'(x[78:64]) - EXT_BIAS + bias;
    if (x[78:64] == EXT_EXP_ONES)
    begin
      // RL4: signaling NaN flags invalid, result is quieted
      fl[EXC_INV] = (f != '0) && !f[EXT_FRAC_W-1];
      kept = (f == '0) ? 64'h0 : (kept | (64'h1 << (nf - 1)));
      ue = emax;
    end
    else if (ue <= 0)
    begin
      // tiny results flush to signed zero; no denormal is produced
      fl[EXC_UN] = (x[63:0] != '0);
      fl[EXC_INX] = (x[63:0] != '0);
      kept = 64'h0;
      ue = 0;
    end
    else
    begin
      // RL25: round by mode and flag inexact
      fl[EXC_INX] = (rem != '0);
      // RL24: rounding mode from control bits
      case (rm)
        RND_NEAREST: inc = (rem > half) || ((rem == half) && kept[0]);
        RND_UP: inc = (rem != '0) && !sgn;
        RND_DOWN: inc = (rem != '0) && sgn;
        default: inc = 1'b0;
      endcase
      kept = kept + {63'h0, inc};
      if (kept[nf])
      begin
        kept = 64'h0;
        ue = ue + 1;
      end
      // RL1: exponent beyond format is overflow
      if (ue >= emax)
      begin
        fl[EXC_OV] = 1'b1;
        fl[EXC_INX] = 1'b1;
        bigInf = (rm == RND_NEAREST) || ((rm == RND_UP) && !sgn) || ((rm == RND_DOWN) && sgn);
        ue = bigInf ? emax : emax - 1;
        kept = bigInf ? 64'h0 : ((64'h1 << nf) - 64'h1);
      end
    end
    return isLong ? {sgn, ue[10:0], kept[51:0]} : {32'h0000_0000, sgn, ue[7:0], kept[22:0]};
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      {rstSync_b, rstMeta_b} <= 2'b00;
    else
      {rstSync_b, rstMeta_b} <= {rstMeta_b, 1'b1};
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [4:0] exc;
    logic [4:0] fl;
    logic resv;
    logic den;
    logic snan;
    logic [79:0] x;
    logic [79:0] w;
    logic [63:0] n;
    logic [4:0] sEven;
    logic [4:0] dEven;
    logic [4:0] sQuad;
    logic [4:0] dQuad;
    logic [31:0] srcWord;
    exc = 5'h00;
    fl = 5'h00;
    resv = 1'b0;
    den = 1'b0;
    snan = 1'b0;
    x = st.fpr[opSrc[1:0]];
    w = 80'h0;
    n = 64'h0;
    // RL12: operands assumed aligned, low index bits ignored
    sEven = {opSrc[4:1], 1'b0};
    dEven = {opDst[4:1], 1'b0};
    sQuad = {opSrc[4:2], 2'b00};
    dQuad = {opDst[4:2], 2'b00};
    srcWord = st.gpr[opSrc];
    next_st = st;
    next_st.done = opValid;
    next_st.faultRes = 1'b0;
    next_st.faultExc = 1'b0;
    next_st.rdData = 32'h0000_0000;
    // unmapped or unaligned reads return zero
    if (regRd && (regAddr == ACW_OFFSET))
      next_st.rdData = st.acw;
    else if (regRd && (regAddr >= GPR_BASE) && (regAddr[1:0] == 2'b00))
      next_st.rdData = st.gpr[regAddr[6:2]];
    // RL18: status fields writable
    // RL19: integer overflow bits writable
    if (regWr && (regAddr == ACW_OFFSET))
      next_st.acw = regWrData & ACW_WMASK;
    else if (regWr && (regAddr >= GPR_BASE) && (regAddr[1:0] == 2'b00))
      next_st.gpr[regAddr[6:2]] = regWrData;
    if (opValid)
    begin
      case (opCode)
        // RL16: bit exact general copy
        OP_MOV1:
          next_st.gpr[opDst] = st.gpr[opSrc];
        OP_MOV2:
          for (int k = 0; k < 2; k++)
            next_st.gpr[dEven + 5'(k)] = st.gpr[sEven + 5'(k)];
        OP_MOV3:
          for (int k = 0; k < 3; k++)
            next_st.gpr[dQuad + 5'(k)] = st.gpr[sQuad + 5'(k)];
        OP_MOVR_G2F, OP_MOVRL_G2F:
        begin
          // RL11: long real in an even/odd pair
          if (opCode == OP_MOVRL_G2F)
            w = widen({st.gpr[sEven + 5'd1], st.gpr[sEven]}, 1'b1, den, snan);
          else
            w = widen({32'h0000_0000, srcWord}, 1'b0, den, snan);
          exc[EXC_INV] = snan;
          // RL23: denormal faults unless normalizing
          resv = den && !st.acw[NORM_BIT];
          // RL13: floating register receives extended form
          if (!resv)
            next_st.fpr[opDst[1:0]] = w;
        end
        OP_MOVRE_G2F:
          // RL15: extract 80 bits from three words
          next_st.fpr[opDst[1:0]] = {st.gpr[sQuad + 5'd2][15:0], st.gpr[sQuad + 5'd1],
                                     st.gpr[sQuad]};
        OP_MOVR_F2G, OP_MOVRL_F2G, OP_ARITH_R, OP_ARITH_RL:
        begin
          if (opCode == OP_ARITH_R || opCode == OP_ARITH_RL)
            x = arithResult;
          // RL8: reserved extended encoding faults
          resv = isReserved(x);
          n = narrow(x, (opCode == OP_MOVRL_F2G) || (opCode == OP_ARITH_RL),
                     st.acw[RND_LSB +: 2], fl);
          exc = resv ? 5'h00
                : (fl | ((opCode == OP_ARITH_R || opCode == OP_ARITH_RL) ? arithExc : 5'h00));
          // RL14: narrowed result, long into a pair
          if (!resv && (opCode == OP_MOVRL_F2G || opCode == OP_ARITH_RL))
          begin
            next_st.gpr[dEven] = n[31:0];
            next_st.gpr[dEven + 5'd1] = n[63:32];
          end
          else if (!resv)
            next_st.gpr[opDst] = n[31:0];
        end
        OP_MOVRE_F2G:
        begin
          // RL15: insert into three-word layout
          next_st.gpr[dQuad] = x[31:0];
          next_st.gpr[dQuad + 5'd1] = x[63:32];
          next_st.gpr[dQuad + 5'd2] = {16'h0000, x[79:64]};
        end
        OP_CLASS:
          // RL2: NaN whatever the sign
          next_st.acw[AS_LSB +: 4] = {srcWord[31],
                                      classify(&srcWord[30:23], ~|srcWord[30:23],
                                               |srcWord[22:0], srcWord[22])};
        OP_CLASSL:
          next_st.acw[AS_LSB +: 4] = {st.gpr[sEven + 5'd1][31],
                                      classify(&st.gpr[sEven + 5'd1][30:20],
                                               ~|st.gpr[sEven + 5'd1][30:20],
                                               |{st.gpr[sEven + 5'd1][19:0], st.gpr[sEven]},
                                               st.gpr[sEven + 5'd1][19])};
        OP_ARITH_FP:
        begin
          // RL17: result kept extended in floating register
          // RL7: integer bit checked at bit 63
          resv = isReserved(arithResult);
          exc = resv ? 5'h00 : arithExc;
          if (!resv)
            next_st.fpr[opDst[1:0]] = arithResult;
        end
        default:
          exc = 5'h00;
      endcase
    end
    // RL20: sticky flags, an event beats a software clear
    next_st.acw[FLAG_LSB +: 5] = next_st.acw[FLAG_LSB +: 5] | exc;
    // RL21: masks gate the fault
    // RL22: fault only when unmasked
    next_st.faultExc = |(exc & ~st.acw[MASK_LSB +: 5]);
    next_st.faultRes = resv;
  end

  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      // RL10: four floating registers cleared
      st <= '{gpr: '0, fpr: '0, acw: ACW_RESET, rdData: 32'h0000_0000,
              done: 1'b0, faultRes: 1'b0, faultExc: 1'b0};
    end
    else
      st <= next_st;
  end

  assign regRdData = st.rdData;
  assign opDone = st.done;
  assign reservedFault = st.faultRes;
  assign excFault = st.faultExc;

  // ****************************************
  // checks
  // ****************************************
  a_ovf_infinity: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL1
    opValid && opCode == OP_MOVR_F2G && st.fpr[opSrc[1:0]][78:63] == 16'hfffd
    && st.acw[RND_LSB +: 2] == RND_NEAREST && !regWr
    |=> st.gpr[$past(opDst)][30:0] == 31'h7f80_0000)
    else $error("overflow did not give infinity");
  a_nan_class: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL2
    opValid && opCode == OP_CLASS && st.gpr[opSrc][30:23] == 8'hff
    && st.gpr[opSrc][22:0] != 23'h0 && !regWr
    |=> st.acw[5:3] == CLS_QNAN || st.acw[5:3] == CLS_SNAN) else $error("NaN not classified");
  a_quiet_decode: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL3
    opValid && opCode == OP_CLASS && st.gpr[opSrc][30:22] == 9'h1ff && !regWr
    |=> st.acw[5:3] == CLS_QNAN) else $error("quiet NaN misdecoded");
  a_snan_invalid: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL4
    opValid && opCode == OP_MOVR_G2F && st.gpr[opSrc][30:22] == 9'h1fe
    && st.gpr[opSrc][21:0] != 22'h0
    |=> st.acw[FLAG_LSB + EXC_INV] && st.fpr[$past(opDst[1:0])][62])
    else $error("signaling NaN missed invalid");
  a_real_bias: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL5
    opValid && opCode == OP_MOVR_G2F && st.gpr[opSrc][30:23] == 8'h80
    |=> st.fpr[$past(opDst[1:0])][78:64] == 15'h4000) else $error("real bias wrong");
  a_ext_intbit: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL7
    opValid && opCode == OP_MOVRL_G2F && st.gpr[{opSrc[4:1], 1'b1}][30:20] != 11'h000
    |=> st.fpr[$past(opDst[1:0])][63] == 1'b1) else $error("integer bit not set");
  a_reserved_fault: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL8
    opValid && opCode == OP_MOVR_F2G && isReserved(st.fpr[opSrc[1:0]]) && !regWr
    |=> reservedFault && st.gpr == $past(st.gpr)) else $error("reserved encoding not faulted");
  a_denorm_fault: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL23
    opValid && opCode == OP_MOVR_G2F && !st.acw[NORM_BIT]
    && st.gpr[opSrc][30:23] == 8'h00 && st.gpr[opSrc][22:0] != 23'h0
    |=> reservedFault && $stable(st.fpr)) else $error("denormal not faulted");
  a_plain_move: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL16
    opValid && opCode == OP_MOV1 && !regWr
    |=> st.gpr[$past(opDst)] == $past(st.gpr[opSrc])) else $error("plain move altered data");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL20
    !(regWr && regAddr == ACW_OFFSET)
    |=> (($past(st.acw[20:16]) & ~st.acw[20:16]) == 5'h00))
    else $error("flag lost without write");
  a_mask_gate: assert property (@(posedge sys_clk) disable iff (!rstSync_b) // RL22
    excFault |-> ($past(st.acw[28:24]) != 5'h1f) && (st.acw[20:16] != 5'h00))
    else $error("fault raised while masked");
endmodule // fpc_unit
`default_nettype wire

// ---- fpc_unit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_unit_test;
  import fpc_pkg::*;
  // ****************************************
  // clock, reset and ports
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [31:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic opValid = 1'b0;
  fpc_op_t opCode = OP_NONE;
  logic [4:0] opSrc = '0;
  logic [4:0] opDst = '0;
  logic [79:0] arithResult = '0;
  logic [4:0] arithExc = '0;
  logic opDone;
  logic reservedFault;
  logic excFault;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] d;
  logic resSeen;
  logic excSeen;

  fpc_unit DUT (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .opValid(opValid), .opCode(opCode),
    .opSrc(opSrc), .opDst(opDst), .arithResult(arithResult), .arithExc(arithExc),
    .opDone(opDone), .reservedFault(reservedFault), .excFault(excFault));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // bus and op helpers
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  function automatic logic [7:0] ga(input int n);
    return GPR_BASE + 8'(4 * n);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(name, exp, d);
  endtask

  task automatic op(input fpc_op_t c, input logic [4:0] s, input logic [4:0] t,
                    input logic [79:0] r = '0, input logic [4:0] e = '0);
    @(posedge sys_clk);
    opValid <= 1'b1;
    opCode <= c;
    opSrc <= s;
    opDst <= t;
    arithResult <= r;
    arithExc <= e;
    @(posedge sys_clk);
    opValid <= 1'b0;
    #1;
    chk("opDone", 32'h1, 32'(opDone));
    resSeen = reservedFault;
    excSeen = excFault;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rc("acw reset", ACW_OFFSET, 32'h3f00_0000);
    wr(ACW_OFFSET, 32'hffff_ffff);
    rc("acw fields", ACW_OFFSET, 32'hff1f_117f);
    wr(ACW_OFFSET, ACW_RESET);
    wr(8'h40, 32'h1234_5678);
    rc("unmapped", 8'h40, 32'h0);
    wr(ga(7), 32'h89ab_cdef);
    rc("gpr word", ga(7), 32'h89ab_cdef);
  endtask

  task automatic t_convert();
    wr(ga(3), 32'h3f80_0000);
    op(OP_MOVR_G2F, 5'd3, 5'd1);
    op(OP_MOVRE_F2G, 5'd1, 5'd4);
    rc("ext low", ga(4), 32'h0);
    rc("ext mid", ga(5), 32'h8000_0000);
    rc("ext top", ga(6), 32'h0000_3fff);
    op(OP_MOVRL_F2G, 5'd1, 5'd8);
    rc("long low", ga(8), 32'h0);
    rc("long high", ga(9), 32'h3ff0_0000);
    op(OP_MOVR_F2G, 5'd1, 5'd2);
    rc("real back", ga(2), 32'h3f80_0000);
    op(OP_MOV2, 5'd8, 5'd10);
    rc("mov2 high", ga(11), 32'h3ff0_0000);
    op(OP_MOVRL_G2F, 5'd8, 5'd0);
    op(OP_MOVRE_F2G, 5'd0, 5'd12);
    rc("long to ext", ga(13), 32'h8000_0000);
    rc("exact no flags", ACW_OFFSET, ACW_RESET);
    op(OP_MOV1, 5'd3, 5'd31);
    rc("mov1 word", ga(31), 32'h3f80_0000);
    op(OP_MOV3, 5'd12, 5'd28);
    rc("mov3 mid", ga(29), 32'h8000_0000);
    rc("mov3 top", ga(30), 32'h0000_3fff);
    wr(ga(3), 32'h4000_0000);
    op(OP_MOVR_G2F, 5'd3, 5'd1);
    op(OP_MOVRE_F2G, 5'd1, 5'd4);
    rc("real bias", ga(6), 32'h0000_4000);
  endtask

  task automatic t_class();
    logic [31:0] val [6] = '{32'h0, 32'h8000_0001, 32'h3f80_0000, 32'hff80_0000,
                             32'h7fc0_0001, 32'h7f80_0001};
    logic [3:0] cls [6] = '{4'h0, 4'h9, 4'h2, 4'hb, 4'h4, 4'h5};
    for (int i = 0; i < 6; i++)
    begin
      wr(ga(20), val[i]);
      op(OP_CLASS, 5'd20, 5'd0);
      rd(ACW_OFFSET);
      chk("class", 32'(cls[i]), 32'(d[6:3]));
    end
    wr(ga(12), 32'h0000_0001);
    wr(ga(13), 32'h7ff0_0000);
    op(OP_CLASSL, 5'd12, 5'd0);
    rd(ACW_OFFSET);
    chk("long class", 32'h5, 32'(d[6:3]));
  endtask

  task automatic t_nan();
    wr(ACW_OFFSET, ACW_RESET);
    wr(ga(2), 32'h7fc0_0000);
    op(OP_MOVR_G2F, 5'd2, 5'd0);
    rc("quiet no flag", ACW_OFFSET, ACW_RESET);
    wr(ga(2), 32'h7f80_0001);
    op(OP_MOVR_G2F, 5'd2, 5'd0);
    chk("masked fault", 32'h0, 32'(excSeen));
    rc("invalid flag", ACW_OFFSET, 32'h3f04_0000);
    // unmask invalid so the fault may show
    wr(ACW_OFFSET, 32'h3b00_0000);
    op(OP_MOVR_G2F, 5'd2, 5'd0);
    chk("unmasked fault", 32'h1, 32'(excSeen));
  endtask

  task automatic t_reserved();
    wr(ACW_OFFSET, ACW_RESET);
    op(OP_ARITH_FP, 5'd0, 5'd3, 80'h4000_8000_0000_0000_0000, 5'h10);
    rc("inexact flag", ACW_OFFSET, 32'h3f10_0000);
    // exponent set, integer bit clear: refused, destination and flags kept
    op(OP_ARITH_FP, 5'd0, 5'd3, 80'h4000_0000_0000_0000_0000, 5'h01);
    chk("reserved fault", 32'h1, 32'(resSeen));
    rc("reserved no flag", ACW_OFFSET, 32'h3f10_0000);
    op(OP_MOVRE_F2G, 5'd3, 5'd20);
    rc("dest kept", ga(21), 32'h8000_0000);
    rc("dest kept exp", ga(22), 32'h0000_4000);
    wr(ga(16), 32'h0);
    wr(ga(17), 32'h0);
    wr(ga(18), 32'h0000_4000);
    op(OP_MOVRE_G2F, 5'd16, 5'd3);
    wr(ga(1), 32'h1357_9bdf);
    op(OP_MOVR_F2G, 5'd3, 5'd1);
    chk("narrow reserved", 32'h1, 32'(resSeen));
    rc("narrow dest kept", ga(1), 32'h1357_9bdf);
    wr(ga(2), 32'h0000_0001);
    wr(ACW_OFFSET, 32'h1f00_0000);
    op(OP_MOVR_G2F, 5'd2, 5'd0);
    chk("denormal fault", 32'h1, 32'(resSeen));
    wr(ACW_OFFSET, ACW_RESET);
    op(OP_MOVR_G2F, 5'd2, 5'd0);
    chk("denormal accepted", 32'h0, 32'(resSeen));
  endtask

  task automatic t_narrow();
    logic [31:0] expv [4] = '{32'h7f80_0000, 32'h7f7f_ffff, 32'h7f80_0000, 32'h7f7f_ffff};
    wr(ga(24), 32'h0);
    wr(ga(25), 32'h8000_0000);
    wr(ga(26), 32'h0000_7ffe);
    op(OP_MOVRE_G2F, 5'd24, 5'd2);
    for (int m = 0; m < 4; m++)
    begin
      wr(ACW_OFFSET, ACW_RESET | (32'(m) << 30));
      op(OP_MOVR_F2G, 5'd2, 5'd1);
      rc("narrow result", ga(1), expv[m]);
      rd(ACW_OFFSET);
      chk("overflow flag", 32'h1, 32'(d[16]));
    end
    wr(ACW_OFFSET, ACW_RESET);
    wr(ga(26), 32'h0000_0001);
    op(OP_MOVRE_G2F, 5'd24, 5'd2);
    op(OP_MOVR_F2G, 5'd2, 5'd1);
    rc("underflow result", ga(1), 32'h0);
    rd(ACW_OFFSET);
    chk("underflow flag", 32'h1, 32'(d[17]));
    wr(ACW_OFFSET, ACW_RESET);
    op(OP_ARITH_RL, 5'd0, 5'd6, 80'h3fff_8000_0000_0000_0000, 5'h08);
    rc("arith long", ga(7), 32'h3ff0_0000);
    rd(ACW_OFFSET);
    chk("zero divide flag", 32'h1, 32'(d[19]));
    op(OP_ARITH_R, 5'd0, 5'd5, 80'hbfff_8000_0000_0000_0000);
    rc("arith real", ga(5), 32'hbf80_0000);
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic conclude();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_convert();
    t_class();
    t_nan();
    t_reserved();
    t_narrow();
    conclude();
  end
endmodule // fpc_unit_test
`default_nettype wire
